// *** design/sssu_pkg.sv ***
// constants shared by the serial shift unit: register map, fields, encodings
// assumes a 32-bit APB master; registers are aligned words
`default_nettype none
package sssu_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_DATA   = 8'h08;

   // control register fields
   localparam int CTRL_START    = 0;
   localparam int CTRL_ABORT    = 1;
   localparam int CTRL_ORDER    = 2;
   localparam int CTRL_MODE_LO  = 3;
   localparam int CTRL_CLK_LO   = 5;

   // status register fields
   localparam int ST_ACTIVE   = 0;
   localparam int ST_SHIFT    = 1;
   localparam int ST_TXEMPTY  = 2;
   localparam int ST_RXFULL   = 3;
   localparam int ST_TX_UNDERRUN_FLAG    = 4;
   localparam int ST_RX_OVERRUN_FLAG    = 5;

   // transfer mode and clock select encodings
   localparam logic [1:0] MODE_TX  = 2'h0;
   localparam logic [1:0] MODE_RX  = 2'h1;
   localparam logic [2:0] CLK_EXT  = 3'h7;
   localparam logic       ORDER_MSB = 1'h0;

   // bits per byte and reset values
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic       TXEMPTY_RST   = 1'h1;
   localparam logic       SCK_IDLE      = 1'h1;
   localparam logic       SO_IDLE       = 1'h1;

   // internal clock: half period in system cycles is HALF_BASE << select
   localparam int HALF_BASE_DEF = 4;
endpackage
`default_nettype wire

// *** design/sssu_top.sv ***
// 8-bit synchronous serial shift unit, transmit-only and receive-only
// assumes APB master on clk_sys; shift clock pin internal or external
//
// Contract
// - order select 0: shift MSB first, bit 7 down to bit 0.
// - order select 1: shift LSB first, bit 0 up to bit 7.
// - mode 00 selects transmit-only operation.
// - mode 01 selects receive-only operation.
// - writing the transmit buffer clears the buffer-empty flag.
// - transfer-active flag rises with first shift clock falling edge after start.
// - transmit drives next bit on each falling shift clock edge.
// - receive samples next bit on each rising shift clock edge.
// - shift-active high from first to eighth falling edge of each byte.
// - buffer-empty set on rise after load; interrupt on next fall.
// - internal clock: transmit waits for buffer data before starting.
// - external clock: buffer loads on first falling edge after start.
// - internal clock: halt clock high when no data; resume within one cycle.
// - byte written before current ends follows with no gap.
// - external underrun sets transmit error, output high, then interrupt.
// - clearing start finishes current byte, clears active, output high.
// - abort stops at once and reinitialises start, flags and buffers.
// - after 8 bits copy to buffer, set full, interrupt; read clears.
// - internal clock receive halts after byte until buffer read.
// - external overrun sets receive error, ignores data; second read shows shifter.
// - clearing receive error after read clears full; interrupts held meanwhile.
// - clock select 111 external; else internal, pin high between transfers.
// - error flags clear only by writing 0 or abort.
`default_nettype none
module sssu_top #(
   parameter int HALF_BASE = sssu_pkg::HALF_BASE_DEF
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // serial pins
   input  wire logic        sckIn,
   output var  logic        sckOut,
   output var  logic        sckOe,
   input  wire logic        serialIn,
   output var  logic        serialOut,
   // event
   output var  logic        serialIrq
);

////////////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers

   logic rstS1, rstS2;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstS1 <= 1'h0;
         rstS2 <= 1'h0;
      end else begin
         rstS1 <= 1'h1;
         rstS2 <= rstS1;
      end
   end
   wire logic rstLocal_n = rstS2;

   // third stage only feeds the edge detector, never the first stage
   logic sckS1, sckS2, sckS3, siS1, siS2;
   always_ff @(posedge clk_sys or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         sckS1 <= 1'h1;
         sckS2 <= 1'h1;
         sckS3 <= 1'h1;
         siS1  <= 1'h1;
         siS2  <= 1'h1;
      end else begin
         sckS1 <= sckIn;
         sckS2 <= sckS1;
         sckS3 <= sckS2;
         siS1  <= serialIn;
         siS2  <= siS1;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// state

   logic        start, order, txEmpty, rxFull, tx_underrun_flag, rx_overrun_flag, active, shiftActive;
   logic        txfPend, irqArm, rxReadOnce, sckInt;
   logic [1:0]  mode;
   logic [2:0]  clkSel;
   logic [3:0]  bitCnt;
   logic [7:0]  txBuf, rxBuf, shiftReg;
   logic [15:0] divCnt;

   logic        next_start, next_order, next_txEmpty, next_rxFull, next_tx_underrun_flag;
   logic        next_rx_overrun_flag, next_active, next_shiftActive, next_txfPend, next_irqArm;
   logic        next_rxReadOnce, next_sckInt, next_sckOe, next_serialOut, next_serialIrq;
   logic        next_pready, next_pslverr;
   logic [1:0]  next_mode;
   logic [2:0]  next_clkSel;
   logic [3:0]  next_bitCnt;
   logic [7:0]  next_txBuf, next_rxBuf, next_shiftReg;
   logic [15:0] next_divCnt;
   logic [31:0] next_prdata;

////////////////////////////////////////////////////////////////////////////////
// decode and shift clock events

   logic        extClk, modeTx, modeOk, running, genEnable, intFall, intRise;
   logic        fallEv, riseEv, apbDone, apbWr, apbRd, abortWr;
   logic [15:0] half;
   logic [7:0]  rxNext;

   always_comb begin
      extClk  = (clkSel == sssu_pkg::CLK_EXT);
      modeTx  = (mode == sssu_pkg::MODE_TX);
      modeOk  = modeTx || (mode == sssu_pkg::MODE_RX);
      half    = 16'(HALF_BASE) << clkSel;
      // internal clock runs only mid-byte or when the next byte can go
      genEnable = (bitCnt != 4'h0)
                  || (start && modeOk && (modeTx ? !txEmpty : !rxFull));
      running = !extClk && genEnable;
      intFall = running && (divCnt == half - 16'h1) && sckInt;
      intRise = running && (divCnt == half - 16'h1) && !sckInt;
      fallEv  = extClk ? (!sckS2 && sckS3) : intFall;
      riseEv  = extClk ? (sckS2 && !sckS3) : intRise;
      // receive shift direction
      rxNext  = (order == sssu_pkg::ORDER_MSB) ? {shiftReg[6:0], siS2}
                                               : {siS2, shiftReg[7:1]};
      apbDone = psel && penable && pready;
      apbWr   = apbDone && pwrite;
      apbRd   = apbDone && !pwrite;
      abortWr = apbWr && (paddr == sssu_pkg::OFF_CTRL) && pwdata[sssu_pkg::CTRL_ABORT];
   end

////////////////////////////////////////////////////////////////////////////////
// next state

   always_comb begin
      next_start       = start;
      next_order       = order;
      next_mode        = mode;
      next_clkSel      = clkSel;
      next_txEmpty     = txEmpty;
      next_rxFull      = rxFull;
      next_tx_underrun_flag       = tx_underrun_flag;
      next_rx_overrun_flag       = rx_overrun_flag;
      next_active      = active;
      next_shiftActive = shiftActive;
      next_txfPend     = txfPend;
      next_irqArm      = irqArm;
      next_rxReadOnce  = rxReadOnce;
      next_bitCnt      = bitCnt;
      next_txBuf       = txBuf;
      next_rxBuf       = rxBuf;
      next_shiftReg    = shiftReg;
      next_serialOut   = serialOut;
      next_serialIrq   = 1'h0;
      next_sckOe       = !extClk;
      next_divCnt      = 16'h0;
      next_sckInt      = sssu_pkg::SCK_IDLE;

      // internal divider; parks high when halted
      if (running) begin
         if (divCnt == half - 16'h1) begin
            next_sckInt = !sckInt;
         end else begin
            next_divCnt = divCnt + 16'h1;
            next_sckInt = sckInt;
         end
      end

      // software side effects first so hardware sets win
      if (apbWr && paddr == sssu_pkg::OFF_CTRL) begin
         next_start  = pwdata[sssu_pkg::CTRL_START];
         next_order  = pwdata[sssu_pkg::CTRL_ORDER];
         next_mode   = pwdata[sssu_pkg::CTRL_MODE_LO +: 2];
         next_clkSel = pwdata[sssu_pkg::CTRL_CLK_LO +: 3];
      end
      if (apbWr && paddr == sssu_pkg::OFF_STATUS) begin
         if (!pwdata[sssu_pkg::ST_TX_UNDERRUN_FLAG]) begin
            next_tx_underrun_flag = 1'h0;
         end
         if (!pwdata[sssu_pkg::ST_RX_OVERRUN_FLAG]) begin
            next_rx_overrun_flag      = 1'h0;
            next_rxReadOnce = 1'h0;
            if (rx_overrun_flag && rxReadOnce) begin
               next_rxFull = 1'h0;
            end
         end
      end
      // a write while the buffer is still full is dropped
      if (apbWr && paddr == sssu_pkg::OFF_DATA && txEmpty) begin
         next_txBuf   = pwdata[7:0];
         next_txEmpty = 1'h0;
      end
      if (apbRd && paddr == sssu_pkg::OFF_DATA) begin
         if (rx_overrun_flag) begin
            next_rxReadOnce = 1'h1;
         end else begin
            next_rxFull = 1'h0;
         end
      end

      // graceful stop between bytes
      if (!start && bitCnt == 4'h0) begin
         next_active = 1'h0;
      end

      // falling shift clock edge
      if (fallEv) begin
         if (irqArm) begin
            next_irqArm    = 1'h0;
            next_serialIrq = !rx_overrun_flag;
         end
         if (bitCnt == 4'h0) begin
            if (start && modeOk) begin
               next_active      = 1'h1;
               next_shiftActive = 1'h1;
               next_bitCnt      = 4'h1;
               if (modeTx) begin
                  if (txEmpty) begin
                     next_tx_underrun_flag     = 1'h1;
                     next_irqArm    = 1'h1;
                     next_serialOut = sssu_pkg::SO_IDLE;
                  end else begin
                     next_txfPend   = 1'h1;
                     if (order == sssu_pkg::ORDER_MSB) begin
                        next_serialOut = txBuf[7];
                        next_shiftReg  = {txBuf[6:0], 1'h0};
                     end else begin
                        next_serialOut = txBuf[0];
                        next_shiftReg  = {1'h0, txBuf[7:1]};
                     end
                  end
               end
            end
         end else if (bitCnt < sssu_pkg::BITS_PER_BYTE) begin
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == sssu_pkg::BITS_PER_BYTE - 4'h1) begin
               next_shiftActive = 1'h0;
            end
            if (modeTx && !tx_underrun_flag) begin
               if (order == sssu_pkg::ORDER_MSB) begin
                  next_serialOut = shiftReg[7];
                  next_shiftReg  = {shiftReg[6:0], 1'h0};
               end else begin
                  next_serialOut = shiftReg[0];
                  next_shiftReg  = {1'h0, shiftReg[7:1]};
               end
            end
         end
      end

      // rising shift clock edge
      if (riseEv) begin
         if (txfPend) begin
            next_txfPend = 1'h0;
            next_txEmpty = 1'h1;
            next_irqArm  = 1'h1;
         end
         if (bitCnt != 4'h0 && !modeTx && !rx_overrun_flag) begin
            next_shiftReg = rxNext;
         end
         if (bitCnt == sssu_pkg::BITS_PER_BYTE) begin
            next_bitCnt = 4'h0;
            if (!modeTx && !rx_overrun_flag) begin
               if (!rxFull) begin
                  next_rxBuf     = rxNext;
                  next_rxFull    = 1'h1;
                  next_serialIrq = 1'h1;
               end else if (extClk) begin
                  next_rx_overrun_flag     = 1'h1;
                  next_serialIrq = 1'h1;
               end
            end
            if (!start) begin
               next_active    = 1'h0;
               next_serialOut = sssu_pkg::SO_IDLE;
            end
         end
      end
      if (tx_underrun_flag) begin
         next_serialOut = sssu_pkg::SO_IDLE;
      end

      // abort overrides everything
      if (apbWr && paddr == sssu_pkg::OFF_CTRL && pwdata[sssu_pkg::CTRL_ABORT]) begin
         next_start       = 1'h0;
         next_txEmpty     = sssu_pkg::TXEMPTY_RST;
         next_rxFull      = 1'h0;
         next_tx_underrun_flag       = 1'h0;
         next_rx_overrun_flag       = 1'h0;
         next_active      = 1'h0;
         next_shiftActive = 1'h0;
         next_txfPend     = 1'h0;
         next_irqArm      = 1'h0;
         next_rxReadOnce  = 1'h0;
         next_bitCnt      = 4'h0;
         next_txBuf       = 8'h00;
         next_rxBuf       = 8'h00;
         next_shiftReg    = 8'h00;
         next_serialOut   = sssu_pkg::SO_IDLE;
         next_serialIrq   = 1'h0;
         next_divCnt      = 16'h0;
         next_sckInt      = sssu_pkg::SCK_IDLE;
      end

      // apb: one wait state so read data comes from a flop
      next_pready  = 1'h0;
      next_pslverr = 1'h0;
      next_prdata  = 32'h0;
      if (psel && penable && !pready) begin
         next_pready = 1'h1;
         unique case (paddr)
            sssu_pkg::OFF_CTRL: begin
               next_prdata[sssu_pkg::CTRL_START]      = start;
               next_prdata[sssu_pkg::CTRL_ORDER]      = order;
               next_prdata[sssu_pkg::CTRL_MODE_LO +: 2] = mode;
               next_prdata[sssu_pkg::CTRL_CLK_LO +: 3]  = clkSel;
            end
            sssu_pkg::OFF_STATUS: begin
               next_prdata[sssu_pkg::ST_ACTIVE]  = active;
               next_prdata[sssu_pkg::ST_SHIFT]   = shiftActive;
               next_prdata[sssu_pkg::ST_TXEMPTY] = txEmpty;
               next_prdata[sssu_pkg::ST_RXFULL]  = rxFull;
               next_prdata[sssu_pkg::ST_TX_UNDERRUN_FLAG]   = tx_underrun_flag;
               next_prdata[sssu_pkg::ST_RX_OVERRUN_FLAG]   = rx_overrun_flag;
            end
            sssu_pkg::OFF_DATA: begin
               next_prdata[7:0] = (rx_overrun_flag && rxReadOnce) ? shiftReg : rxBuf;
            end
            default: begin
               next_pslverr = 1'h1;
            end
         endcase
      end
   end

////////////////////////////////////////////////////////////////////////////////
// registers

   always_ff @(posedge clk_sys or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         start       <= 1'h0;
         order       <= 1'h0;
         mode        <= 2'h0;
         clkSel      <= 3'h0;
         txEmpty     <= sssu_pkg::TXEMPTY_RST;
         rxFull      <= 1'h0;
         tx_underrun_flag       <= 1'h0;
         rx_overrun_flag       <= 1'h0;
         active      <= 1'h0;
         shiftActive <= 1'h0;
         txfPend     <= 1'h0;
         irqArm      <= 1'h0;
         rxReadOnce  <= 1'h0;
         bitCnt      <= 4'h0;
         txBuf       <= 8'h00;
         rxBuf       <= 8'h00;
         shiftReg    <= 8'h00;
         divCnt      <= 16'h0;
         sckInt      <= sssu_pkg::SCK_IDLE;
         sckOe       <= 1'h1;
         serialOut   <= sssu_pkg::SO_IDLE;
         serialIrq   <= 1'h0;
         pready      <= 1'h0;
         pslverr     <= 1'h0;
         prdata      <= 32'h0;
      end else begin
         start       <= next_start;
         order       <= next_order;
         mode        <= next_mode;
         clkSel      <= next_clkSel;
         txEmpty     <= next_txEmpty;
         rxFull      <= next_rxFull;
         tx_underrun_flag       <= next_tx_underrun_flag;
         rx_overrun_flag       <= next_rx_overrun_flag;
         active      <= next_active;
         shiftActive <= next_shiftActive;
         txfPend     <= next_txfPend;
         irqArm      <= next_irqArm;
         rxReadOnce  <= next_rxReadOnce;
         bitCnt      <= next_bitCnt;
         txBuf       <= next_txBuf;
         rxBuf       <= next_rxBuf;
         shiftReg    <= next_shiftReg;
         divCnt      <= next_divCnt;
         sckInt      <= next_sckInt;
         sckOe       <= next_sckOe;
         serialOut   <= next_serialOut;
         serialIrq   <= next_serialIrq;
         pready      <= next_pready;
         pslverr     <= next_pslverr;
         prdata      <= next_prdata;
      end
   end
   assign sckOut = sckInt;

////////////////////////////////////////////////////////////////////////////////
// assertions

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstLocal_n);

   sequence sDataWrite;
      apbWr && paddr == sssu_pkg::OFF_DATA && txEmpty;
   endsequence
   sequence sAbort;
      apbWr && paddr == sssu_pkg::OFF_CTRL && pwdata[sssu_pkg::CTRL_ABORT];
   endsequence

   a_tx_write_clr: assert property (sDataWrite |=> !txEmpty)
      else $error("buffer-empty not cleared by write");
   a_abort_init: assert property (sAbort |=> !start && !active && !tx_underrun_flag && !rx_overrun_flag
                                  && txEmpty && !rxFull && bitCnt == 4'h0)
      else $error("abort did not reinitialise");
   a_active_rise: assert property ($rose(active) |-> $past(fallEv))
      else $error("active rose without falling edge");
   a_shift_end: assert property ($fell(shiftActive) && !$past(abortWr)
                                 |-> bitCnt == sssu_pkg::BITS_PER_BYTE)
      else $error("shift-active ended before eighth edge");
   a_halt_high: assert property (!extClk && !genEnable |=> sckOut)
      else $error("internal clock not parked high");
   a_ext_oe: assert property (extClk |=> !sckOe ##1 sckOut)
      else $error("pin driven in external clock mode");
   a_overrun_set: assert property (riseEv && extClk && !modeTx && rxFull && !rx_overrun_flag
                                   && bitCnt == sssu_pkg::BITS_PER_BYTE
                                   && !abortWr |=> rx_overrun_flag && serialIrq)
      else $error("overrun not flagged");
   a_err_sticky: assert property (tx_underrun_flag && !(apbWr && paddr == sssu_pkg::OFF_STATUS)
                                  && !abortWr |=> tx_underrun_flag)
      else $error("transmit error cleared without a write");
   a_tx_underrun_flag_out: assert property (tx_underrun_flag |=> serialOut [*2])
      else $error("output not held high on underrun");
   a_irq_quiet: assert property (rx_overrun_flag && $past(rx_overrun_flag) |-> !serialIrq)
      else $error("interrupt raised during receive error");

endmodule
`default_nettype wire

// *** bench/sssu_peer.sv ***
// partner model: external serial peer on the shared shift clock wire
// assumes the bench feeds sck with the resolved shift clock wire
`default_nettype none
module sssu_peer (
   // shared shift clock
   input  wire logic sck,
   output var  logic sckDrv,
   // serial data
   input  wire logic serialOut,
   output var  logic serialIn
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] txSh = 8'hA5;
   logic [7:0] cap  = 8'h00;
   int         bits = 0;

   initial begin
      sckDrv = 1'b1;
      serialIn = 1'b1;
   end

   // new bit on each fall; idle pattern keeps changing, never a stale level
   always @(negedge sck) begin
      serialIn <= txSh[7];
      txSh <= {txSh[6:0], ~txSh[7]};
   end

   always @(posedge sck) begin
      cap <= {cap[6:0], serialOut};
      bits <= bits + 1;
   end

   // clock stands high outside frames; 80 ns phases keep well above min width
   task automatic frame();
      repeat (8) begin
         sckDrv <= 1'b0;
         #80 sckDrv <= 1'b1;
         #80;
      end
   endtask
endmodule
`default_nettype wire

// *** bench/tb_sync_serial_shift_unit.sv ***
// self-checking bench: apb master tasks, peer model, random bytes
// assumes sssu_pkg, sssu_top and sssu_peer are compiled first
`default_nettype none
module tb_sync_serial_shift_unit;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////
   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, sckOut, sckOe, sckDrv, serialIn, serialOut, serialIrq;
   wire logic   sckWire = sckOe ? sckOut : sckDrv;
   int          failures = 0;
   int          checked  = 0;
   int          irqs     = 0;
   int          seed     = 96841;
   int          n0;
   logic [31:0] r;
   logic        e, o;
   logic [7:0]  b0, b1, b2;

   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (serialIrq === 1'b1) irqs <= irqs + 1;

   sssu_top #(.HALF_BASE(2)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sckIn(sckWire), .sckOut(sckOut), .sckOe(sckOe),
      .serialIn(serialIn), .serialOut(serialOut), .serialIrq(serialIrq));
   sssu_peer peer_u (.sck(sckWire), .sckDrv(sckDrv), .serialOut(serialOut),
      .serialIn(serialIn));
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (failures == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic chkBit(input string nm, input logic ex, input logic got);
      chk(nm, {31'h0, ex}, {31'h0, got});
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         chk("apb ready", 32'h1, 32'h0);
         conclude();
      end
   endtask

   task automatic rdSt();
      apb(1'b0, sssu_pkg::OFF_STATUS, 32'h0);
   endtask

   task automatic abortChk();
      apb(1'b1, sssu_pkg::OFF_CTRL, 32'h2);
      rdSt();
      chk("status after abort", 32'h4, r);
   endtask

   task automatic waitBits(input int target, input int lim);
      for (int i = 0; i < lim && peer_u.bits < target; i++) @(posedge clk_sys);
      chk("shift clock rises", target, peer_u.bits);
      if (peer_u.bits < target) conclude();
   endtask

   task automatic rxByte(input logic [7:0] v);
      peer_u.txSh = o ? rev(v) : v;
      peer_u.frame();
      repeat (8) @(posedge clk_sys);
   endtask

   function automatic logic [7:0] rev(input logic [7:0] v);
      return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
   endfunction

   function automatic logic [31:0] ctl(input logic ord, input logic [1:0] m,
                                       input logic [2:0] c);
      return {24'h0, c, m, ord, 2'b01};
   endfunction

   function automatic logic [7:0] rnd8();
      logic [31:0] t;
      t = $random(seed);
      return t[7:0];
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdSt();
      chk("status after reset", 32'h4, r);
      apb(1'b1, 8'h0C, 32'h1);
      chkBit("unmapped error", 1'b1, e);
      for (int k = 0; k < 2; k++) begin
         o = k[0];
         b0 = rnd8();
         b1 = rnd8();
         b2 = rnd8();
         // internal clock transmit, second byte queued mid-byte
         apb(1'b1, sssu_pkg::OFF_CTRL, ctl(o, sssu_pkg::MODE_TX, 3'h0));
         n0 = peer_u.bits;
         repeat (20) @(posedge clk_sys);
         chk("waits for data", n0, peer_u.bits);
         apb(1'b1, sssu_pkg::OFF_DATA, {24'h0, b0});
         n0 = peer_u.bits;
         r = 32'h0;
         for (int i = 0; i < 20 && r[sssu_pkg::ST_TXEMPTY] !== 1'b1; i++) rdSt();
         chkBit("tx empty after load", 1'b1, r[sssu_pkg::ST_TXEMPTY]);
         apb(1'b1, sssu_pkg::OFF_DATA, {24'h0, b1});
         waitBits(n0 + 8, 60);
         chk("tx byte first", {24'h0, o ? rev(b0) : b0}, {24'h0, peer_u.cap});
         waitBits(n0 + 16, 34);
         chk("tx byte next", {24'h0, o ? rev(b1) : b1}, {24'h0, peer_u.cap});
         n0 = peer_u.bits;
         repeat (40) @(posedge clk_sys);
         chk("parked clock", n0, peer_u.bits);
         chkBit("parked high", 1'b1, sckOut);
         chkBit("clock driven", 1'b1, sckOe);
         abortChk();
         // external clock receive, then overrun
         apb(1'b1, sssu_pkg::OFF_CTRL, ctl(o, sssu_pkg::MODE_RX, sssu_pkg::CLK_EXT));
         n0 = irqs;
         rxByte(b0);
         rdSt();
         chkBit("rx full", 1'b1, r[sssu_pkg::ST_RXFULL]);
         chkBit("clock released", 1'b0, sckOe);
         apb(1'b0, sssu_pkg::OFF_DATA, 32'h0);
         chk("rx byte", {24'h0, b0}, r);
         rdSt();
         chkBit("rx full cleared", 1'b0, r[sssu_pkg::ST_RXFULL]);
         rxByte(b1);
         rxByte(b2);
         rdSt();
         chkBit("rx error", 1'b1, r[sssu_pkg::ST_RX_OVERRUN_FLAG]);
         chk("irq count", n0 + 3, irqs);
         apb(1'b0, sssu_pkg::OFF_DATA, 32'h0);
         chk("rx kept byte", {24'h0, b1}, r);
         apb(1'b0, sssu_pkg::OFF_DATA, 32'h0);
         chk("rx shifter byte", {24'h0, b2}, r);
         apb(1'b1, sssu_pkg::OFF_STATUS, 32'h20);
         rdSt();
         chkBit("rx error kept", 1'b1, r[sssu_pkg::ST_RX_OVERRUN_FLAG]);
         apb(1'b1, sssu_pkg::OFF_STATUS, 32'h0);
         rdSt();
         chk("rx flags cleared", 32'h0, {30'h0, r[5], r[3]});
         abortChk();
      end
      // internal clock receive, lsb first; half period 4 covers the input sync delay
      b1 = rnd8();
      peer_u.txSh = rev(b1);
      apb(1'b1, sssu_pkg::OFF_CTRL, ctl(1'b1, sssu_pkg::MODE_RX, 3'h1));
      n0 = peer_u.bits;
      waitBits(n0 + 8, 80);
      repeat (40) @(posedge clk_sys);
      chk("rx parked", n0 + 8, peer_u.bits);
      apb(1'b0, sssu_pkg::OFF_DATA, 32'h0);
      chk("rx internal byte", {24'h0, b1}, r);
      waitBits(n0 + 9, 30);
      abortChk();
      // external clock transmit, then underrun
      b0 = rnd8();
      apb(1'b1, sssu_pkg::OFF_DATA, {24'h0, b0});
      rdSt();
      chkBit("tx empty cleared", 1'b0, r[sssu_pkg::ST_TXEMPTY]);
      apb(1'b1, sssu_pkg::OFF_CTRL, ctl(1'b0, sssu_pkg::MODE_TX, sssu_pkg::CLK_EXT));
      peer_u.frame();
      chk("ext tx byte", {24'h0, b0}, {24'h0, peer_u.cap});
      peer_u.frame();
      rdSt();
      chkBit("tx error", 1'b1, r[sssu_pkg::ST_TX_UNDERRUN_FLAG]);
      chk("underrun output", 32'hFF, {24'h0, peer_u.cap});
      apb(1'b1, sssu_pkg::OFF_STATUS, 32'h10);
      rdSt();
      chkBit("tx error kept", 1'b1, r[sssu_pkg::ST_TX_UNDERRUN_FLAG]);
      abortChk();
      // external receive: start cleared between bytes stops the next one
      o = 1'b0;
      apb(1'b1, sssu_pkg::OFF_CTRL, ctl(1'b0, sssu_pkg::MODE_RX, sssu_pkg::CLK_EXT));
      rxByte(b2);
      apb(1'b1, sssu_pkg::OFF_CTRL, ctl(1'b0, sssu_pkg::MODE_RX, sssu_pkg::CLK_EXT) ^ 32'h1);
      rxByte(b0);
      rdSt();
      chk("stop after byte", 32'hC, r);
      apb(1'b0, sssu_pkg::OFF_DATA, 32'h0);
      chk("rx byte kept", {24'h0, b2}, r);
      conclude();
   end
endmodule
`default_nettype wire
